/* File: verilog/serial_status_defs.svh */
// Register offsets, field positions, reset values and bit timing
// Assumes byte-wide registers on a 3-bit word address
`ifndef SERIAL_STATUS_DEFS_SVH
`define SERIAL_STATUS_DEFS_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define ADR_STATUS 3'h0
`define ADR_DATA 3'h1
`define ADR_CTRL_TWO 3'h2
`define ADR_CTRL_ONE 3'h3
`define ADR_DIVISOR 3'h4
// ----------------------------------------
// Status bits
// ----------------------------------------
`define S_TXE 3'h7
`define S_CMPL 3'h6
`define S_RXF 3'h5
`define S_IDLE 3'h4
`define S_OVR 3'h3
`define S_NOISE 3'h2
`define S_FRAME 3'h1
`define S_PARITY 3'h0
`define STATUS_RESET 8'hc0
// ----------------------------------------
// Control bits
// ----------------------------------------
`define C2_TXON 3'h3
`define C2_BRK 3'h0
`define C1_LBK 3'h5
`define C1_NINE 3'h4
`define C1_AFTER_STOP 3'h2
`define C1_PAR_ON 3'h1
`define C1_ODD 3'h0
`define DIVISOR_RESET 8'h00
// ----------------------------------------
// Bit timing in oversample ticks, frame lengths in bits
// ----------------------------------------
`define OVS_LAST 4'hf
`define SAMP_START 4'h4
`define SAMP_DATA 4'h8
`define SAMP_DECIDE 4'ha
`define FRAME_8 4'ha
`define FRAME_9 4'hb
`define IDLE_8 8'ha0
`define IDLE_9 8'hb0
`endif

/* File: verilog/serial_status_pkg.sv */
// Types shared by the serial status block
// Assumes the defs header carries all numeric constants
package serial_status_pkg;
  typedef enum logic {RX_IDLE, RX_FRAME} rx_state_e;
  typedef logic [7:0] byte_t;
endpackage : serial_status_pkg

/* File: verilog/async_serial_status_flags.sv */
// Serial transceiver with its eight status flags
// Assumes a single-cycle strobe bus and an rxd synchronous to ref_clk_in
//
// What this block does
// - Status register read-only, writes ignored
// - Transmit empty sets at reset, buffer move
// - Status read then data write clears it
// - Complete sets when buffer empty, shifter idle
// - Status read then data write, transmitter on or break clears complete
// - Receive full sets on character transfer
// - Status read then data read clears full
// - Idle after one full high character time
// - Idle count start chosen by select bit
// - Status read then data read clears idle
// - Idle sets once per character moved into the receive buffer
// - Overrun sets, new character discarded
// - Status read then data read clears overrun
// - Majority sampling, disagreement sets noise
// - Status read then data read clears noise
// - Zero stop bit sets framing error
// - Status read then data read clears framing
// - Parity mismatch sets parity error
// - Status read then data read clears parity
// - Long break detect blocks full and framing
// - Parity occupies the character MSB
//
// The placing of the registers and the plain strobed port were left to the implementer.
`include "serial_status_defs.svh"
module async_serial_status_flags
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Register port
  input wire logic [2:0] addr_in,
  input wire serial_status_pkg::byte_t wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output serial_status_pkg::byte_t rd_data_out,
  // Serial line
  input wire logic rxd_in,
  output logic txd_out
);
  import serial_status_pkg::*;

  // ----------------------------------------
  // Registers and decode
  // ----------------------------------------
  byte_t status_r, arm_r, rx_data_r, tx_buf_r, div_r, div_cnt_r;
  logic txon_r, brk_r, lbk_r, nine_r, after_stop_r, par_on_r, odd_r, tick_r;
  logic st_rd, data_rd, data_wr, c2_wr, txon_rise, brk_wr, cmpl_ev;
  assign st_rd = rd_en_in && addr_in == `ADR_STATUS;
  assign data_rd = rd_en_in && addr_in == `ADR_DATA;
  assign data_wr = wr_en_in && addr_in == `ADR_DATA;
  assign c2_wr = wr_en_in && addr_in == `ADR_CTRL_TWO;
  assign txon_rise = c2_wr && wr_data_in[`C2_TXON] && !txon_r;
  assign brk_wr = c2_wr && wr_data_in[`C2_BRK];
  assign cmpl_ev = data_wr || txon_rise || brk_wr;

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      txon_r <= 1'b0;
      brk_r <= 1'b0;
      {lbk_r, nine_r, after_stop_r, par_on_r, odd_r} <= 5'h00;
      div_r <= `DIVISOR_RESET;
    end
    else if (c2_wr)
    begin
      txon_r <= wr_data_in[`C2_TXON];
      brk_r <= wr_data_in[`C2_BRK];
    end
    else if (wr_en_in && addr_in == `ADR_CTRL_ONE)
    begin
      lbk_r <= wr_data_in[`C1_LBK];
      nine_r <= wr_data_in[`C1_NINE];
      after_stop_r <= wr_data_in[`C1_AFTER_STOP];
      par_on_r <= wr_data_in[`C1_PAR_ON];
      odd_r <= wr_data_in[`C1_ODD];
    end
    else if (wr_en_in && addr_in == `ADR_DIVISOR)
      div_r <= wr_data_in;
  end

  // Status writes fall through every branch above
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      rd_data_out <= 8'h00;
    else if (rd_en_in)
    begin
      case (addr_in)
        `ADR_STATUS: rd_data_out <= status_r;
        `ADR_DATA: rd_data_out <= rx_data_r;
        `ADR_CTRL_TWO: rd_data_out <= {4'h0, txon_r, 2'h0, brk_r};
        `ADR_CTRL_ONE: rd_data_out <= {2'h0, lbk_r, nine_r, 1'b0, after_stop_r, par_on_r, odd_r};
        `ADR_DIVISOR: rd_data_out <= div_r;
        default: rd_data_out <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Oversample tick, sixteen per bit
  // ----------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      div_cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= div_cnt_r == div_r;
      div_cnt_r <= (div_cnt_r == div_r) ? 8'h00 : div_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  rx_state_e rx_state_r;
  logic [3:0] rx_ovs_r, rx_bit_r, stop_idx;
  logic [2:0] ones_r, cnt_r, ones_all, cnt_all;
  logic [8:0] rx_sh_r;
  logic noise_r, samp, decide, bit_val, noisy, char_done, perr;
  assign stop_idx = (nine_r ? `FRAME_9 : `FRAME_8) - 4'h1;
  // Seven samples in the start bit, three in the others
  assign samp = rx_ovs_r >= (rx_bit_r == 4'h0 ? `SAMP_START : `SAMP_DATA)
    && rx_ovs_r <= `SAMP_DECIDE;
  assign decide = rx_state_r == RX_FRAME && tick_r && rx_ovs_r == `SAMP_DECIDE;
  assign ones_all = ones_r + {2'h0, rxd_in};
  assign cnt_all = cnt_r + 3'h1;
  assign bit_val = {ones_all, 1'b0} > {1'b0, cnt_all};
  assign noisy = ones_all != 3'h0 && ones_all != cnt_all;
  assign char_done = decide && rx_bit_r == stop_idx;
  // Expected parity over all data bits, the MSB being parity
  assign perr = par_on_r && ((nine_r ? ^rx_sh_r : ^rx_sh_r[8:1]) != odd_r);

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      rx_state_r <= RX_IDLE;
      rx_ovs_r <= 4'h0;
      rx_bit_r <= 4'h0;
      ones_r <= 3'h0;
      cnt_r <= 3'h0;
      noise_r <= 1'b0;
      rx_sh_r <= 9'h000;
    end
    else if (tick_r)
    begin
      case (rx_state_r)
        RX_IDLE:
        begin
          if (!rxd_in)
            rx_state_r <= RX_FRAME;
          rx_ovs_r <= 4'h1;
          rx_bit_r <= 4'h0;
          ones_r <= 3'h0;
          cnt_r <= 3'h0;
          noise_r <= 1'b0;
        end
        RX_FRAME:
        begin
          rx_ovs_r <= rx_ovs_r + 4'h1;
          if (samp)
          begin
            ones_r <= ones_all;
            cnt_r <= cnt_all;
          end
          if (decide)
          begin
            noise_r <= noise_r | noisy;
            if (rx_bit_r == 4'h0 && bit_val)
              rx_state_r <= RX_IDLE;
            else if (rx_bit_r == stop_idx)
              rx_state_r <= RX_IDLE;
            else if (rx_bit_r != 4'h0)
              rx_sh_r <= {bit_val, rx_sh_r[8:1]};
          end
          if (rx_ovs_r == `OVS_LAST)
          begin
            rx_bit_r <= rx_bit_r + 4'h1;
            ones_r <= 3'h0;
            cnt_r <= 3'h0;
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Idle line detection
  // ----------------------------------------
  logic [7:0] idle_cnt_r, idle_lim;
  logic idle_ok, idle_hit, idle_armed_r;
  assign idle_lim = nine_r ? `IDLE_9 : `IDLE_8;
  // Select bit moves the count start past the stop bit
  assign idle_ok = after_stop_r ? rx_state_r == RX_IDLE
    : !(rx_state_r == RX_FRAME && rx_bit_r == 4'h0);
  assign idle_hit = tick_r && rxd_in && idle_ok && idle_cnt_r == idle_lim - 8'h01;

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      idle_cnt_r <= 8'h00;
    else if (tick_r)
    begin
      if (!rxd_in || !idle_ok)
        idle_cnt_r <= 8'h00;
      else if (idle_cnt_r != idle_lim)
        idle_cnt_r <= idle_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  logic [11:0] tx_sh_r;
  logic [3:0] tx_ovs_r, tx_left_r;
  logic tx_busy_r, tx_buf_full_r, pre_q_r, brk_q_r, tx_go, tx_end;
  logic [7:0] d;
  assign d = tx_buf_r;
  assign tx_go = !tx_busy_r && txon_r;
  assign tx_end = tx_busy_r && tick_r && tx_ovs_r == `OVS_LAST && tx_left_r == 4'h1;

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      tx_busy_r <= 1'b0;
      tx_sh_r <= 12'hfff;
      tx_ovs_r <= 4'h0;
      tx_left_r <= 4'h0;
      tx_buf_full_r <= 1'b0;
      pre_q_r <= 1'b0;
      brk_q_r <= 1'b0;
      tx_buf_r <= 8'h00;
    end
    else
    begin
      if (txon_rise)
        pre_q_r <= 1'b1;
      if (brk_wr)
        brk_q_r <= 1'b1;
      if (data_wr)
      begin
        tx_buf_r <= wr_data_in;
        tx_buf_full_r <= 1'b1;
      end
      if (tx_go && (pre_q_r || brk_q_r || brk_r || tx_buf_full_r))
      begin
        tx_busy_r <= 1'b1;
        tx_ovs_r <= 4'h0;
        tx_left_r <= nine_r ? `FRAME_9 : `FRAME_8;
        if (pre_q_r)
        begin
          pre_q_r <= txon_rise;
          tx_sh_r <= 12'hfff;
        end
        else if (brk_q_r || brk_r)
        begin
          brk_q_r <= brk_wr;
          tx_sh_r <= 12'h000;
        end
        else
        begin
          tx_buf_full_r <= data_wr;
          if (nine_r)
            tx_sh_r <= {2'h3, par_on_r ? odd_r ^ ^d : 1'b1, d, 1'b0};
          else
            tx_sh_r <= {3'h7, par_on_r ? odd_r ^ ^d[6:0] : d[7], d[6:0], 1'b0};
        end
      end
      else if (tx_busy_r && tick_r)
      begin
        tx_ovs_r <= tx_ovs_r + 4'h1;
        if (tx_ovs_r == `OVS_LAST)
        begin
          tx_sh_r <= {1'b1, tx_sh_r[11:1]};
          tx_left_r <= tx_left_r - 4'h1;
          if (tx_left_r == 4'h1)
            tx_busy_r <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      txd_out <= 1'b1;
    else
      txd_out <= tx_busy_r ? tx_sh_r[0] : 1'b1;
  end

  // ----------------------------------------
  // Status flags and clear sequences
  // ----------------------------------------
  logic tx_load, receive_buffer_full_busy, receive_buffer_full_set, ovr_set, idle_set, cmpl_set;
  byte_t set_v, clr_v;
  assign tx_load = tx_go && tx_buf_full_r && !pre_q_r && !brk_q_r && !brk_r;
  // A transfer in the clearing cycle has found the buffer read
  assign receive_buffer_full_busy = status_r[`S_RXF] && !clr_v[`S_RXF];
  assign receive_buffer_full_set = char_done && !lbk_r && !receive_buffer_full_busy;
  assign ovr_set = char_done && !lbk_r && receive_buffer_full_busy;
  assign idle_set = idle_hit && idle_armed_r;
  assign cmpl_set = tx_end && !tx_buf_full_r && !pre_q_r && !brk_q_r && !brk_r;
  assign set_v = {tx_load, cmpl_set, receive_buffer_full_set, idle_set, ovr_set,
    receive_buffer_full_set && (noise_r || noisy), receive_buffer_full_set && !bit_val, receive_buffer_full_set && perr};
  assign clr_v = arm_r & {data_wr, cmpl_ev, {6{data_rd}}};

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      status_r <= `STATUS_RESET;
    else
      status_r <= (status_r & ~clr_v) | set_v;
  end

  // Only flags seen set by the status read may be cleared
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      arm_r <= 8'h00;
    else if (st_rd)
      arm_r <= status_r;
    else
      arm_r <= arm_r & ~{data_wr, cmpl_ev, {6{data_rd}}};
  end

  // Overrun drops the character and its error bits
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      rx_data_r <= 8'h00;
    else if (receive_buffer_full_set)
      rx_data_r <= nine_r ? rx_sh_r[7:0] : rx_sh_r[8:1];
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      idle_armed_r <= 1'b0;
    else if (receive_buffer_full_set)
      idle_armed_r <= 1'b1;
    else if (idle_set)
      idle_armed_r <= 1'b0;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence rxf_seen;
    st_rd && status_r[`S_RXF];
  endsequence
  sequence rxf_taken;
    data_rd && !receive_buffer_full_set;
  endsequence
  sequence txe_seen;
    st_rd && status_r[`S_TXE];
  endsequence
  sequence txe_taken;
    data_wr && !tx_load;
  endsequence

  wr_ignore_a: assert property (
    wr_en_in && addr_in == `ADR_STATUS && set_v == 8'h00 |=> $stable(status_r))
    else $error("status write changed flags");
  txe_set_a: assert property (tx_load |=> status_r[`S_TXE] && tx_busy_r)
    else $error("transmit empty not set on load");
  txe_clr_a: assert property (txe_seen ##1 txe_taken |=> !status_r[`S_TXE])
    else $error("transmit empty not cleared");
  cmpl_clr_a: assert property (
    arm_r[`S_CMPL] && cmpl_ev && !cmpl_set |=> !status_r[`S_CMPL])
    else $error("complete not cleared");
  rxf_clr_a: assert property (rxf_seen ##1 rxf_taken |=> !status_r[`S_RXF])
    else $error("receive full not cleared");
  lbk_block_a: assert property (
    char_done && lbk_r && !data_rd |=> $stable(status_r[`S_RXF]) && !$rose(status_r[`S_FRAME]))
    else $error("long break let flags set");
  ovr_drop_a: assert property (ovr_set |=> status_r[`S_OVR] && $stable(rx_data_r))
    else $error("overrun mishandled");
  idle_once_a: assert property (idle_set |=> status_r[`S_IDLE] && !idle_armed_r)
    else $error("idle not single shot");
  frame_set_a: assert property (
    receive_buffer_full_set && !bit_val |=> status_r[`S_FRAME] && status_r[`S_RXF])
    else $error("framing error missing");
endmodule : async_serial_status_flags

/* File: testbench/serial_node_model.sv */
// Remote serial node: drives the receive line and decodes the transmit line
// Assumes a divisor of 0, so one oversample tick per clock and 16 per bit
module serial_node_model
(
  // Clock
  input wire logic clk_in,
  // Serial line
  input wire logic txd_in,
  output logic rxd_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx_seen;
  initial rxd_out = 1'b1;
  // ----------------------------------------
  // Frame sender
  // ----------------------------------------
  // A low stop bit is lifted late in its bit time so the receiver cannot take it as a start
  task send(input logic [8:0] d, input int n, input logic stp, input logic nz);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    f[n + 1] = stp;
    for (int i = 0; i <= n + 1; i++)
      for (int t = 0; t < 16; t++)
      begin
        @(posedge clk_in);
        rxd_out <= (f[i] | (i == n + 1 && t > 10)) ^ (nz && i == 1 && t == 9);
      end
    @(posedge clk_in);
    rxd_out <= 1'b1;
  endtask : send
  // ----------------------------------------
  // Transmit line decoder, mid-bit sampling
  // ----------------------------------------
  initial
  begin
    tx_seen = 8'h00;
    forever
    begin
      @(negedge txd_in);
      repeat (8) @(posedge clk_in);
      for (int i = 0; i < 8; i++)
      begin
        repeat (16) @(posedge clk_in);
        tx_seen[i] = txd_in;
      end
      repeat (16) @(posedge clk_in);
    end
  end
endmodule : serial_node_model

/* File: testbench/async_serial_status_flags_tb_top.sv */
// Self-checking bench for the serial status flags
// Assumes the divisor stays at its reset value of 0
`include "serial_status_defs.svh"
module async_serial_status_flags_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import serial_status_pkg::*;
  typedef struct {byte_t c1; logic [8:0] d; int n; logic stp; logic nz; byte_t st;} row_s;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  byte_t wr_data_in = 8'h00;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  byte_t rd_data_out;
  logic rxd_in;
  logic txd_out;
  int err_total = 0;
  int n_compared = 0;
  byte_t v;
  // Control one, frame, data bits, stop level, noise, status expected
  row_s rows [8] = '{
    '{8'h00, 9'h055, 8, 1'b1, 1'b0, 8'hf0},
    '{8'h00, 9'h0a3, 8, 1'b0, 1'b0, 8'hf2},
    '{8'h00, 9'h00f, 8, 1'b1, 1'b1, 8'hf4},
    '{8'h02, 9'h083, 8, 1'b1, 1'b0, 8'hf1},
    '{8'h03, 9'h083, 8, 1'b1, 1'b0, 8'hf0},
    '{8'h04, 9'h0ff, 8, 1'b1, 1'b0, 8'hf0},
    '{8'h10, 9'h1c4, 9, 1'b1, 1'b0, 8'hf0},
    '{8'h20, 9'h077, 8, 1'b0, 1'b0, 8'hc0}};
  always #20 ref_clk_in = ~ref_clk_in;
  async_serial_status_flags dut
  (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .addr_in(addr_in),
    .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out),
    .rxd_in(rxd_in),
    .txd_out(txd_out)
  );
  serial_node_model node
  (
    .clk_in(ref_clk_in),
    .txd_in(txd_out),
    .rxd_out(rxd_in)
  );
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task chk(input string what, input byte_t seen, input byte_t exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task wr(input logic [2:0] a, input byte_t d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_en_in <= 1'b0;
  endtask : wr
  // Read data stand from the cycle after the strobe until the next read
  task rd(input logic [2:0] a, output byte_t d);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_en_in <= 1'b0;
    #1;
    d = rd_data_out;
  endtask : rd
  task rdc(input logic [2:0] a, input byte_t exp, input string what);
    rd(a, v);
    chk(what, v, exp);
  endtask : rdc
  task idle_wait(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : idle_wait
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // Hang guard
  // ----------------------------------------
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    err_total++;
    close_out;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    rdc(`ADR_STATUS, 8'hc0, "reset status");
    wr(`ADR_STATUS, 8'h00);
    rdc(`ADR_STATUS, 8'hc0, "status after write");
    rdc(3'h7, 8'h00, "unmapped");
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(`ADR_CTRL_ONE, rows[i].c1);
      node.send(rows[i].d, rows[i].n, rows[i].stp, rows[i].nz);
      idle_wait(208);
      rdc(`ADR_STATUS, rows[i].st, "status");
      rd(`ADR_DATA, v);
      if (rows[i].st[5])
        chk("data", v, rows[i].d[7:0]);
      rdc(`ADR_STATUS, 8'hc0, "cleared");
      $display("test row %0d done", i);
    end
    // A flag set after the status read must survive the data read
    wr(`ADR_CTRL_ONE, 8'h00);
    rdc(`ADR_STATUS, 8'hc0, "before frame");
    node.send(9'h011, 8, 1'b1, 1'b0);
    idle_wait(208);
    rd(`ADR_DATA, v);
    rdc(`ADR_STATUS, 8'hf0, "unarmed clear");
    rd(`ADR_DATA, v);
    idle_wait(208);
    rdc(`ADR_STATUS, 8'hc0, "idle once");
    node.send(9'h021, 8, 1'b1, 1'b0);
    node.send(9'h042, 8, 1'b1, 1'b0);
    idle_wait(208);
    rdc(`ADR_STATUS, 8'hf8, "overrun");
    rdc(`ADR_DATA, 8'h21, "first byte kept");
    rdc(`ADR_STATUS, 8'hc0, "overrun cleared");
    // All-ones character: counting from just after the start bit finds idle far sooner
    node.send(9'h0ff, 8, 1'b1, 1'b0);
    idle_wait(60);
    rdc(`ADR_STATUS, 8'hf0, "idle from start");
    rd(`ADR_DATA, v);
    wr(`ADR_CTRL_ONE, 8'h04);
    node.send(9'h0ff, 8, 1'b1, 1'b0);
    idle_wait(60);
    rdc(`ADR_STATUS, 8'he0, "idle not yet");
    idle_wait(150);
    rdc(`ADR_STATUS, 8'hf0, "idle from stop");
    rd(`ADR_DATA, v);
    $display("test receive extras done");
    wr(`ADR_CTRL_TWO, 8'h08);
    rdc(`ADR_STATUS, 8'h80, "preamble");
    idle_wait(200);
    rdc(`ADR_STATUS, 8'hc0, "preamble done");
    wr(`ADR_DATA, 8'h5a);
    rdc(`ADR_STATUS, 8'h80, "sending");
    idle_wait(200);
    chk("tx byte", node.tx_seen, 8'h5a);
    rdc(`ADR_STATUS, 8'hc0, "tx done");
    wr(`ADR_CTRL_TWO, 8'h09);
    wr(`ADR_CTRL_TWO, 8'h08);
    rdc(`ADR_STATUS, 8'h80, "break queued");
    idle_wait(220);
    rdc(`ADR_STATUS, 8'hc0, "break done");
    $display("test transmit done");
    close_out;
  end
endmodule : async_serial_status_flags_tb_top
